// ---- vta_regs.sv ----
// Our own choice: the APB slave port.
module vta_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Search engine side
  output vta_pkg::vta_cfg_t cfg_r,
  output logic key_cfg_valid,
  output logic field_a_enable,
  output logic field_b_enable,
  input wire logic sweep_start,
  input wire logic service_step,
  output logic [15:0] sweep_index,
  output logic sweep_active,
  output logic sweep_restricted,
  // SRAM port
  output logic sram_en,
  output logic sram_we,
  output logic [19:0] sram_addr,
  output logic [39:0] sram_wdata,
  input wire logic [39:0] sram_rdata,
  output logic sram_busy
);
  import vta_pkg::*;

  logic [39:0] stage_wr_r;
  logic [39:0] stage_rd;
  logic [19:0] addr_r;
  logic rnw_r;
  logic launch_r;
  logic busy;
  logic done;
  logic [5:0] age_r;
  logic late_r;
  logic [7:0] idx;
  logic bus_wr;
  logic bus_rd_err;
  logic hit;
  vta_sram_req_t req;

  assign idx = paddr[9:2];
  assign bus_wr = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (idx)
      VTA_IDX_DATA_LOW, VTA_IDX_DATA_MID, VTA_IDX_DATA_TOP, VTA_IDX_MAX_INDEX,
      VTA_IDX_KEY_SETUP, VTA_IDX_FIELD_A, VTA_IDX_FIELD_B, VTA_IDX_ACCESS,
      VTA_IDX_SWEEP: hit = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
      default: hit = 1'b0;
    endcase
  end

  assign bus_rd_err = 1'b0;
  assign pslverr = psel && penable && (!hit || bus_rd_err);

  // Write staging data; reads never see it directly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_wr_r <= VTA_WORD_RST;
    end else if (bus_wr && hit) begin
      case (idx)
        VTA_IDX_DATA_LOW: stage_wr_r[15:0] <= pwdata[15:0];
        VTA_IDX_DATA_MID: stage_wr_r[31:16] <= pwdata[15:0];
        VTA_IDX_DATA_TOP: stage_wr_r[39:32] <= pwdata[7:0];
        default: stage_wr_r <= stage_wr_r;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r.max_table_index <= VTA_MAX_INDEX_RST;
      cfg_r.port_id_bit_count <= VTA_PORT_BITS_RST;
      cfg_r.field_a_start <= VTA_START_RST;
      cfg_r.field_a_length <= VTA_LEN_A_RST;
      cfg_r.field_b_start <= VTA_START_RST;
      cfg_r.field_b_length <= VTA_LEN_B_RST;
    end else if (bus_wr && hit) begin
      case (idx)
        VTA_IDX_MAX_INDEX: cfg_r.max_table_index <= pwdata[15:0];
        VTA_IDX_KEY_SETUP: cfg_r.port_id_bit_count <= pwdata[VTA_PORT_LSB+:3];
        VTA_IDX_FIELD_A: begin
          cfg_r.field_a_length <= pwdata[VTA_LEN_LSB+:5];
          cfg_r.field_a_start <= pwdata[6:0];
        end
        VTA_IDX_FIELD_B: begin
          cfg_r.field_b_length <= pwdata[VTA_LEN_LSB+:4];
          cfg_r.field_b_start <= pwdata[6:0];
        end
        default: cfg_r.max_table_index <= cfg_r.max_table_index;
      endcase
    end
  end

  // Reserved port code or over-range lengths disable the key build
  assign key_cfg_valid = (cfg_r.port_id_bit_count <= VTA_PORT_BITS_MAX)
    && (cfg_r.field_a_length <= VTA_LEN_A_MAX)
    && (cfg_r.field_b_length <= VTA_LEN_B_MAX);
  assign field_a_enable = (cfg_r.field_a_length != VTA_LEN_A_RST);
  assign field_b_enable = (cfg_r.field_b_length != VTA_LEN_B_RST);
  assign sweep_restricted = (cfg_r.max_table_index == VTA_MAX_INDEX_RST);

  // Access control write launches a request; ignored while busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_r <= VTA_ADDR_RST;
      rnw_r <= 1'b0;
      launch_r <= 1'b0;
    end else begin
      launch_r <= 1'b0;
      if (bus_wr && hit && (idx == VTA_IDX_ACCESS) && !busy && !launch_r) begin
        addr_r <= pwdata[19:0];
        rnw_r <= pwdata[VTA_RNW_BIT+16];
        launch_r <= 1'b1;
      end
    end
  end

  assign req.req = launch_r;
  assign req.read_not_write = rnw_r;
  assign req.sram_record_address = addr_r;
  assign req.wdata = stage_wr_r;

  vta_sram_seq u_seq (
    .clk(clk),
    .rst(rst),
    .req(req),
    .busy(busy),
    .done(done),
    .rdata_r(stage_rd),
    .sram_en_r(sram_en),
    .sram_we_r(sram_we),
    .sram_addr_r(sram_addr),
    .sram_wdata_r(sram_wdata),
    .sram_rdata(sram_rdata)
  );

  assign sram_busy = busy || launch_r;

  // Completion age counter flags an access exceeding the bound
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age_r <= 6'h00;
      late_r <= 1'b0;
    end else if (launch_r) begin
      age_r <= 6'h00;
    end else if (busy) begin
      age_r <= age_r + 6'h01;
      if (int'(age_r) >= VTA_ACCESS_CYCLES) begin
        late_r <= 1'b1;
      end
    end
  end

  vta_sweep u_sweep (
    .clk(clk),
    .rst(rst),
    .max_table_index(cfg_r.max_table_index),
    .sweep_start(sweep_start),
    .service_step(service_step),
    .sweep_index_r(sweep_index),
    .sweep_active_r(sweep_active)
  );

  // Read mux; staging reads show captured SRAM data
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite && hit) begin
      case (idx)
        VTA_IDX_DATA_LOW: prdata[15:0] = stage_rd[15:0];
        VTA_IDX_DATA_MID: prdata[15:0] = stage_rd[31:16];
        VTA_IDX_DATA_TOP: prdata[7:0] = stage_rd[39:32];
        VTA_IDX_MAX_INDEX: prdata[15:0] = cfg_r.max_table_index;
        VTA_IDX_KEY_SETUP: prdata[VTA_PORT_LSB+:3] = cfg_r.port_id_bit_count;
        VTA_IDX_FIELD_A: begin
          prdata[VTA_LEN_LSB+:5] = cfg_r.field_a_length;
          prdata[6:0] = cfg_r.field_a_start;
        end
        VTA_IDX_FIELD_B: begin
          prdata[VTA_LEN_LSB+:4] = cfg_r.field_b_length;
          prdata[6:0] = cfg_r.field_b_start;
        end
        VTA_IDX_ACCESS: begin
          prdata[19:0] = addr_r;
          prdata[VTA_RNW_BIT+16] = rnw_r;
          prdata[VTA_BUSY_BIT+16] = sram_busy;
          prdata[29] = late_r;
        end
        VTA_IDX_SWEEP: begin
          prdata[15:0] = sweep_index;
          prdata[16] = sweep_active;
        end
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule // vta_regs

// ---- vta_pkg.sv ----
package vta_pkg;

  // Register offsets (printed offsets are register indexes; byte address is four times)
  localparam logic [7:0] VTA_IDX_DATA_LOW = 8'h23;
  localparam logic [7:0] VTA_IDX_DATA_MID = 8'h24;
  localparam logic [7:0] VTA_IDX_DATA_TOP = 8'h25;
  localparam logic [7:0] VTA_IDX_MAX_INDEX = 8'h26;
  localparam logic [7:0] VTA_IDX_KEY_SETUP = 8'h27;
  localparam logic [7:0] VTA_IDX_FIELD_A = 8'h28;
  localparam logic [7:0] VTA_IDX_FIELD_B = 8'h29;
  localparam logic [7:0] VTA_IDX_ACCESS = 8'h2A;
  localparam logic [7:0] VTA_IDX_SWEEP = 8'h2B;

  // Field positions
  localparam int VTA_RNW_BIT = 15;
  localparam int VTA_BUSY_BIT = 14;
  localparam int VTA_LEN_LSB = 8;
  localparam int VTA_PORT_LSB = 8;

  // Reset values
  localparam logic [15:0] VTA_MAX_INDEX_RST = 16'h0000;
  localparam logic [2:0] VTA_PORT_BITS_RST = 3'h0;
  localparam logic [6:0] VTA_START_RST = 7'h00;
  localparam logic [4:0] VTA_LEN_A_RST = 5'h00;
  localparam logic [3:0] VTA_LEN_B_RST = 4'h0;
  localparam logic [19:0] VTA_ADDR_RST = 20'h00000;
  localparam logic [39:0] VTA_WORD_RST = 40'h00_0000_0000;

  // Limits and timing
  localparam logic [2:0] VTA_PORT_BITS_MAX = 3'h5;
  localparam logic [4:0] VTA_LEN_A_MAX = 5'h10;
  localparam logic [3:0] VTA_LEN_B_MAX = 4'hB;
  localparam int VTA_CLK_MHZ = 20;
  localparam int VTA_ACCESS_NS = 1850;
  localparam int VTA_ACCESS_CYCLES = (VTA_ACCESS_NS * VTA_CLK_MHZ) / 1000;
  localparam logic [5:0] VTA_SRAM_LATENCY = 6'h02;

  typedef struct packed {
    logic [15:0] max_table_index;
    logic [2:0] port_id_bit_count;
    logic [6:0] field_a_start;
    logic [4:0] field_a_length;
    logic [6:0] field_b_start;
    logic [3:0] field_b_length;
  } vta_cfg_t;

  typedef struct packed {
    logic req;
    logic read_not_write;
    logic [19:0] sram_record_address;
    logic [39:0] wdata;
  } vta_sram_req_t;

  typedef enum logic [1:0] {
    VTA_IDLE,
    VTA_ISSUE,
    VTA_WAIT
  } vta_acc_state_t;

endpackage

// ---- vta_sram_seq.sv ----
module vta_sram_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from registers
  input vta_pkg::vta_sram_req_t req,
  output logic busy,
  output logic done,
  output logic [39:0] rdata_r,
  // SRAM port
  output logic sram_en_r,
  output logic sram_we_r,
  output logic [19:0] sram_addr_r,
  output logic [39:0] sram_wdata_r,
  input wire logic [39:0] sram_rdata
);
  import vta_pkg::*;

  vta_acc_state_t state_r;
  logic [5:0] wait_r;
  logic rnw_r;

  assign busy = (state_r != VTA_IDLE);
  assign done = (state_r == VTA_WAIT) && (wait_r == 6'h00);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= VTA_IDLE;
      wait_r <= 6'h00;
      rnw_r <= 1'b0;
    end else begin
      case (state_r)
        VTA_IDLE: begin
          if (req.req) begin
            state_r <= VTA_ISSUE;
            rnw_r <= req.read_not_write;
          end
        end
        VTA_ISSUE: begin
          state_r <= VTA_WAIT;
          wait_r <= VTA_SRAM_LATENCY;
        end
        VTA_WAIT: begin
          if (wait_r == 6'h00) begin
            state_r <= VTA_IDLE;
          end else begin
            wait_r <= wait_r - 6'h01;
          end
        end
        default: state_r <= VTA_IDLE;
      endcase
    end
  end

  // One-cycle SRAM strobe in the issue state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sram_en_r <= 1'b0;
      sram_we_r <= 1'b0;
      sram_addr_r <= VTA_ADDR_RST;
      sram_wdata_r <= VTA_WORD_RST;
    end else begin
      sram_en_r <= (state_r == VTA_IDLE) && req.req;
      sram_we_r <= (state_r == VTA_IDLE) && req.req && !req.read_not_write;
      if ((state_r == VTA_IDLE) && req.req) begin
        sram_addr_r <= req.sram_record_address;
        sram_wdata_r <= req.wdata;
      end
    end
  end

  // Capture read data at completion only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= VTA_WORD_RST;
    end else if (done && rnw_r) begin
      rdata_r <= sram_rdata;
    end
  end
endmodule // vta_sram_seq

// ---- vta_sweep.sv ----
module vta_sweep (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic [15:0] max_table_index,
  input wire logic sweep_start,
  input wire logic service_step,
  // Status
  output logic [15:0] sweep_index_r,
  output logic sweep_active_r
);
  import vta_pkg::*;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sweep_index_r <= VTA_MAX_INDEX_RST;
      sweep_active_r <= 1'b0;
    end else if (sweep_start) begin
      sweep_index_r <= max_table_index;
      sweep_active_r <= 1'b1;
    end else if (sweep_active_r && service_step) begin
      if (sweep_index_r == 16'h0000) begin
        sweep_active_r <= 1'b0;
      end else begin
        sweep_index_r <= sweep_index_r - 16'h0001;
      end
    end
  end
endmodule // vta_sweep

// ---- vta_sram_model.sv ----
module vta_sram_model (
  // Clock
  input wire logic clk,
  // SRAM port
  input wire logic sram_en,
  input wire logic sram_we,
  input wire logic [19:0] sram_addr,
  input wire logic [39:0] sram_wdata,
  output logic [39:0] sram_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [39:0] mem [16];
  logic [39:0] q = 40'h00_0000_0000;
  int age = 9;
  always @(posedge clk) begin
    age <= age + 1;
    if (sram_en && sram_we) mem[sram_addr[3:0]] <= sram_wdata;
    if (sram_en && !sram_we) begin
      q <= mem[sram_addr[3:0]];
      age <= 0;
    end
  end
  // Read data goes stale after its hold window
  assign sram_rdata = (age < 4) ? q : ~q;
endmodule // vta_sram_model

// ---- vta_regs_asserts.sv ----
module vta_regs_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Watched outputs and sweep inputs
  input wire vta_pkg::vta_cfg_t cfg_r,
  input wire logic key_cfg_valid,
  input wire logic field_a_enable,
  input wire logic field_b_enable,
  input wire logic sweep_start,
  input wire logic service_step,
  input wire logic [15:0] sweep_index,
  input wire logic sweep_active,
  input wire logic sweep_restricted,
  input wire logic sram_en,
  input wire logic sram_we,
  input wire logic sram_busy
);
  import vta_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic acc_wr;
  assign acc_wr = psel && penable && pwrite && paddr[9:2] == VTA_IDX_ACCESS && !sram_busy;
  property p_busy;
    acc_wr |=> sram_busy ##[1:36] !sram_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy span wrong");
  property p_rd_no_we;
    acc_wr && pwdata[31] |=> !sram_we [*8];
  endproperty
  a_rd_no_we: assert property (p_rd_no_we) else $error("write on read");
  property p_wr_pulse;
    acc_wr && !pwdata[31] |-> ##[1:36] (sram_en && sram_we);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("no write pulse");
  property p_rd_en;
    acc_wr && pwdata[31] |-> ##[1:36] sram_en;
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("no read access");
  property p_restrict;
    sweep_restricted == (cfg_r.max_table_index == 16'h0000);
  endproperty
  a_restrict: assert property (p_restrict) else $error("restrict wrong");
  property p_key_ok;
    key_cfg_valid == (cfg_r.port_id_bit_count <= VTA_PORT_BITS_MAX &&
      cfg_r.field_a_length <= VTA_LEN_A_MAX && cfg_r.field_b_length <= VTA_LEN_B_MAX);
  endproperty
  a_key_ok: assert property (p_key_ok) else $error("key valid wrong");
  property p_field_en;
    field_a_enable == (cfg_r.field_a_length != 5'h00) &&
      field_b_enable == (cfg_r.field_b_length != 4'h0);
  endproperty
  a_field_en: assert property (p_field_en) else $error("enable wrong");
  property p_load;
    sweep_start |=> sweep_active && sweep_index == $past(cfg_r.max_table_index);
  endproperty
  a_load: assert property (p_load) else $error("sweep load wrong");
  property p_dec;
    service_step && !sweep_start && sweep_active && sweep_index != 16'h0000
      |=> sweep_index == $past(sweep_index) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("sweep step wrong");
  c_read: cover property (acc_wr && pwdata[31]);
  c_write: cover property (acc_wr && !pwdata[31]);
  c_sweep: cover property (sweep_start ##2 service_step);
endmodule // vta_regs_asserts

bind vta_regs vta_regs_asserts u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .cfg_r, .key_cfg_valid, .field_a_enable, .field_b_enable, .sweep_start, .service_step,
  .sweep_index, .sweep_active, .sweep_restricted, .sram_en, .sram_we, .sram_busy);

// ---- test_vta_regs.sv ----
module test_vta_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import vta_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
    logic [15:0] wd;
    logic [15:0] rb;
    logic kv;
  } vta_row_t;
  logic clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  vta_cfg_t cfg_r;
  logic key_cfg_valid;
  logic field_a_enable;
  logic field_b_enable;
  logic sweep_start = 0;
  logic service_step = 0;
  logic [15:0] sweep_index;
  logic sweep_active;
  logic sweep_restricted;
  logic sram_en;
  logic sram_we;
  logic [19:0] sram_addr;
  logic [39:0] sram_wdata;
  logic [39:0] sram_rdata;
  logic sram_busy;
  int fails = 0;
  int check_count = 0;
  int n;
  logic [31:0] rd;
  logic er;
  logic [15:0] sx [3] = '{16'h5678, 16'h1234, 16'h00A5};
  vta_row_t rows [9] = '{
    '{8'h26, 16'hFFFF, 16'hFFFF, 1'b1}, '{8'h27, 16'h0500, 16'h0500, 1'b1},
    '{8'h27, 16'h0600, 16'h0600, 1'b0}, '{8'h27, 16'h0300, 16'h0300, 1'b1},
    '{8'h28, 16'hFFFF, 16'h1F7F, 1'b0}, '{8'h28, 16'h0A77, 16'h0A77, 1'b1},
    '{8'h29, 16'hFFFF, 16'h0F7F, 1'b0}, '{8'h29, 16'h0B05, 16'h0B05, 1'b1},
    '{8'h26, 16'h0000, 16'h0000, 1'b1}};
  always #25 clk = ~clk;
  vta_regs DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cfg_r, .key_cfg_valid, .field_a_enable, .field_b_enable, .sweep_start,
    .service_step, .sweep_index, .sweep_active, .sweep_restricted, .sram_en, .sram_we,
    .sram_addr, .sram_wdata, .sram_rdata, .sram_busy);
  vta_sram_model u_mem (.clk, .sram_en, .sram_we, .sram_addr, .sram_wdata, .sram_rdata);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Launch an access, then poll busy like software would
  task automatic sram_op(input logic rnw, input logic [19:0] a);
    apb(1'b1, VTA_IDX_ACCESS, {rnw, 11'h000, a});
    n = 0;
    do begin
      apb(1'b0, VTA_IDX_ACCESS, 32'h0000_0000);
      n++;
    end while (rd[30] !== 1'b0 && n < 20);
    chk("access cycles", 32'h1, 32'(n * 3 <= 37));
    chk("access rnw", 32'(rnw), 32'(rd[31]));
    chk("access addr", 32'(a), 32'(rd[19:0]));
    chk("late flag", 32'h0, 32'(rd[29]));
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #(3000 * 50);
    fails++;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, VTA_IDX_MAX_INDEX, 32'h0000_0000);
    chk("max reset", 32'(VTA_MAX_INDEX_RST), rd);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, {16'h0000, rows[i].wd});
      apb(1'b0, rows[i].idx, 32'h0000_0000);
      chk("readback", 32'(rows[i].rb), rd);
      chk("key valid", 32'(rows[i].kv), 32'(key_cfg_valid));
    end
    chk("start a", 32'h77, 32'(cfg_r.field_a_start));
    chk("enable a", 32'h1, 32'(field_a_enable));
    chk("enable b", 32'h1, 32'(field_b_enable));
    chk("restricted", 32'h1, 32'(sweep_restricted));
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("slverr", 32'h1, 32'(er));
    for (int i = 0; i < 3; i++) apb(1'b1, VTA_IDX_DATA_LOW + 8'(i), 32'(sx[i]));
    sram_op(1'b0, 20'h00003);
    apb(1'b0, VTA_IDX_DATA_MID, 32'h0000_0000);
    chk("stage echo", 32'h0, rd);
    sram_op(1'b1, 20'h00003);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, VTA_IDX_DATA_LOW + 8'(i), 32'h0000_0000);
      chk("stage word", 32'(sx[i]), rd);
    end
    apb(1'b1, VTA_IDX_MAX_INDEX, 32'h0000_0003);
    chk("restricted", 32'h0, 32'(sweep_restricted));
    sweep_start <= 1'b1;
    @(posedge clk);
    sweep_start <= 1'b0;
    @(posedge clk);
    for (int i = 3; i >= 0; i--) begin
      chk("sweep index", 32'(i), 32'(sweep_index));
      service_step <= 1'b1;
      @(posedge clk);
      service_step <= 1'b0;
      @(posedge clk);
    end
    chk("sweep done", 32'h0, 32'(sweep_active));
    // All ones starts the sweep at the top record
    apb(1'b1, VTA_IDX_MAX_INDEX, 32'h0000_FFFF);
    sweep_start <= 1'b1;
    @(posedge clk);
    sweep_start <= 1'b0;
    service_step <= 1'b1;
    @(posedge clk);
    service_step <= 1'b0;
    @(posedge clk);
    chk("full sweep", 32'hFFFE, 32'(sweep_index));
    chk("full active", 32'h1, 32'(sweep_active));
    // Reset in mid-run returns every register to its reset value
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset max", 32'(VTA_MAX_INDEX_RST), 32'(cfg_r.max_table_index));
    chk("reset active", 32'h0, 32'(sweep_active));
    chk("reset enables", 32'h0, 32'({field_a_enable, field_b_enable}));
    chk("reset restricted", 32'h1, 32'(sweep_restricted));
    apb(1'b0, VTA_IDX_DATA_LOW, 32'h0000_0000);
    chk("reset stage", 32'h0, rd);
    end_of_test;
  end
endmodule // test_vta_regs
